// *** core/wtu_pkg.sv ***
package wtu_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CYC_PER_US      = CLK_HZ / 1_000_000;
  localparam int unsigned AUTO_TIMEOUT_MS = 100;
  localparam int unsigned AUTO_TIMEOUT_CYC = AUTO_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned SCREEN_DIVS     = 10;

  // ---------------------------------------------------------------
  // sample and level scaling
  // ---------------------------------------------------------------
  localparam int          SMP_W        = 16;
  localparam int          CODE_W       = 18;
  localparam int          NUM_CH       = 8;
  // sample code that equals one measurement range
  localparam int          RANGE_CODE   = 1000;
  // level is programmed in tenths of a percent
  localparam int          LVL_W        = 11;
  localparam int          LVL_MAX      = 1000;
  localparam int          CF_LO        = 3;
  localparam int          CF_HI        = 6;
  localparam int          HYST_PCT_LO  = 2;
  localparam int          HYST_PCT_HI  = 4;
  localparam int          HYST_CODE_LO = CF_LO * RANGE_CODE * HYST_PCT_LO / 100;
  localparam int          HYST_CODE_HI = CF_HI * RANGE_CODE * HYST_PCT_HI / 100;
  localparam logic [3:0]  SRC_EXT      = 4'h8;
  localparam int          TDIV_N       = 17;
  localparam int          TDIV_W       = 5;

  typedef logic signed [SMP_W-1:0]  wtu_smp_t;
  typedef logic signed [CODE_W-1:0] wtu_code_t;
  typedef wtu_smp_t [NUM_CH-1:0]    wtu_chans_t;

  typedef enum logic [1:0] {WTU_SLOPE_RISE, WTU_SLOPE_FALL, WTU_SLOPE_BOTH} wtu_slope_t;
  typedef enum logic {WTU_MODE_AUTO, WTU_MODE_NORMAL} wtu_mode_t;

  typedef struct packed {
    wtu_mode_t               mode;
    wtu_slope_t              slope;
    logic [3:0]              src;       // 0..7 = U1,I1,..,U4,I4 ; 8 = external
    logic signed [LVL_W-1:0] level;     // -1000..1000 tenths of percent
    logic                    cf_hi;     // crest factor 6 when set, else 3
    logic [TDIV_W-1:0]       tdiv_sel;  // 1-2-5 index, 0 = 1 us/div
  } wtu_cfg_t;

  // 1-2-5 sequence of time per division in microseconds
  function automatic logic [31:0] tdiv_us(input logic [TDIV_W-1:0] idx);
    logic [31:0] dec;
    logic [31:0] mant;
    dec  = 32'h1;
    mant = 32'h1;
    for (int k = 0; k < 6; k++) begin
      if (32'(idx) / 3 > k) begin
        dec = dec * 32'ha;
      end
    end
    case (32'(idx) % 3)
      1:       mant = 32'h2;
      2:       mant = 32'h5;
      default: mant = 32'h1;
    endcase
    return mant * dec;
  endfunction : tdiv_us

endpackage : wtu_pkg

// *** core/wtu_edge.sv ***
`timescale 1ns/1ps
`default_nettype none

module wtu_edge (
  input  wire logic               i_clk_sys,
  input  wire logic               i_sys_rst,
  input  wire logic               i_valid,
  input  wire wtu_pkg::wtu_code_t i_sample,
  input  wire wtu_pkg::wtu_code_t i_level,
  input  wire wtu_pkg::wtu_code_t i_hyst,
  input  wire wtu_pkg::wtu_slope_t i_slope,
  output logic                    o_fire
);
  import wtu_pkg::*;

  wtu_code_t prev_r;
  logic      have_prev_r;
  logic      arm_up_r;
  logic      arm_dn_r;
  logic      fire_r;

  wire       below    = i_sample < i_level - i_hyst;
  wire       above    = i_sample > i_level + i_hyst;
  // compare the new sample and the previous one against the level
  wire       up_x     = i_valid && have_prev_r && arm_up_r && prev_r < i_level && i_sample >= i_level;
  wire       dn_x     = i_valid && have_prev_r && arm_dn_r && prev_r > i_level && i_sample <= i_level;
  wire       want_up  = i_slope == WTU_SLOPE_RISE || i_slope == WTU_SLOPE_BOTH;
  wire       want_dn  = i_slope == WTU_SLOPE_FALL || i_slope == WTU_SLOPE_BOTH;
  wire       fire_nxt = (want_up && up_x) || (want_dn && dn_x);
  // a fired direction re-arms only after leaving the hysteresis band
  wire       arm_up_nxt = (i_valid && below) ? 1'b1 : (up_x ? 1'b0 : arm_up_r);
  wire       arm_dn_nxt = (i_valid && above) ? 1'b1 : (dn_x ? 1'b0 : arm_dn_r);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      prev_r      <= '0;
      have_prev_r <= 1'b0;
      arm_up_r    <= 1'b0;
      arm_dn_r    <= 1'b0;
      fire_r      <= 1'b0;
    end else begin
      if (i_valid) begin
        prev_r      <= i_sample;
        have_prev_r <= 1'b1;
      end
      arm_up_r <= arm_up_nxt;
      arm_dn_r <= arm_dn_nxt;
      fire_r   <= fire_nxt;
    end
  end

  assign o_fire = fire_r;

  property p_rise_fire;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_slope == WTU_SLOPE_RISE && up_x) |=> o_fire;
  endproperty
  a_rise_fire: assert property (p_rise_fire) else $error("rising crossing did not fire");

  property p_fall_fire;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_slope == WTU_SLOPE_FALL && dn_x) |=> o_fire;
  endproperty
  a_fall_fire: assert property (p_fall_fire) else $error("falling crossing did not fire");

  property p_both_fire;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_slope == WTU_SLOPE_BOTH && (up_x || dn_x)) |=> o_fire;
  endproperty
  a_both_fire: assert property (p_both_fire) else $error("crossing missed in both-edge slope");

  property p_rise_only;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (i_slope == WTU_SLOPE_RISE && !up_x) |=> !o_fire;
  endproperty
  a_rise_only: assert property (p_rise_only) else $error("rising slope fired without upward crossing");

  property p_hyst_rearm;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      up_x |=> !arm_up_r;
  endproperty
  a_hyst_rearm: assert property (p_hyst_rearm) else $error("upward arm not dropped after crossing");

endmodule : wtu_edge

`default_nettype wire

// *** core/wtu_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - auto mode refreshes on trigger, or on its own after about 100 ms timeout.
// - normal mode refreshes only on a trigger, or each interval during integration; otherwise display stays unchanged.
// - rising slope fires when source crosses level upward from below.
// - falling slope fires when source crosses level downward from above.
// - both-edge slope fires on a crossing in either direction.
// - level is signed percent up to plus/minus 100.0, zero at input zero line.
// - full scale is three times range at crest 3, six times at crest 6.
// - source is any of eight element channels or the external input.
// - external source ignores level and triggers on the TTL signal.
// - external edge is registered within one microsecond plus one sample.
// - with waveforms shown and no integration, measure only after a trigger or, in auto mode, after the timeout.
// - integration running or suspended disables trigger; refresh every interval.
// - time per division steps 1-2-5, largest makes one screen equal the interval.
// - screen starts at time zero and ends at the full screen duration.
// - crossing uses about 2 percent hysteresis at crest 3, 4 percent at 6.
module wtu_top #(
  parameter int unsigned TIMEOUT_CYC = wtu_pkg::AUTO_TIMEOUT_CYC
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_sys_rst,
  input  wire wtu_pkg::wtu_cfg_t  i_cfg,
  input  wire wtu_pkg::wtu_chans_t i_chans,
  input  wire logic               i_smp_valid,
  input  wire logic               i_ext_trig,
  input  wire logic               i_update_tick,
  input  wire logic [31:0]        i_interval_us,
  input  wire logic               i_wave_on,
  input  wire logic               i_integ_run,
  input  wire logic               i_integ_susp,
  output logic                    o_trig,
  output logic                    o_frame_start,
  output logic                    o_capturing,
  output logic                    o_refresh,
  output logic                    o_auto_refresh,
  output logic [31:0]             o_screen_cyc,
  output logic [wtu_pkg::TDIV_W-1:0] o_tdiv_eff,
  output logic                    o_trig_wait
);
  import wtu_pkg::*;

  typedef enum logic [1:0] {WTU_IDLE, WTU_WAIT, WTU_CAPT} wtu_state_t;

  wtu_state_t  state_r;
  wtu_state_t  state_nxt;
  logic [31:0] tmo_r;
  logic [31:0] cnt_r;
  logic [31:0] screen_r;
  logic        ext_prev_r;
  logic        ext_edge_r;
  logic        frame_r;
  logic        refresh_r;
  logic        auto_r;
  logic [TDIV_W-1:0] tdiv_r;
  logic        ch_fire;

  // ---------------------------------------------------------------
  // level and source
  // ---------------------------------------------------------------
  wire signed [LVL_W-1:0]  lvl_max   = LVL_W'(LVL_MAX);
  wire signed [LVL_W-1:0]  lvl_clip  = (i_cfg.level > lvl_max) ? lvl_max :
                                       (i_cfg.level < -lvl_max) ? -lvl_max : i_cfg.level;
  // samples carry RANGE_CODE per range, so tenths-of-percent times crest is the code
  wire wtu_code_t          cf_code   = i_cfg.cf_hi ? CODE_W'(CF_HI) : CODE_W'(CF_LO);
  wire wtu_code_t          lvl_code  = CODE_W'(CODE_W'(lvl_clip) * cf_code);
  wire wtu_code_t          hyst_code = i_cfg.cf_hi ? CODE_W'(HYST_CODE_HI) : CODE_W'(HYST_CODE_LO);
  wire                     src_ext   = i_cfg.src == SRC_EXT;
  wire                     src_ch    = i_cfg.src < SRC_EXT;
  wire wtu_code_t          smp_code  = CODE_W'(i_chans[i_cfg.src[2:0]]);
  wire                     integ_on  = i_integ_run || i_integ_susp;

  wtu_edge u_edge (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .i_valid   (i_smp_valid && src_ch),
    .i_sample  (smp_code),
    .i_level   (lvl_code),
    .i_hyst    (hyst_code),
    .i_slope   (i_cfg.slope),
    .o_fire    (ch_fire)
  );

  // ---------------------------------------------------------------
  // external trigger
  // ---------------------------------------------------------------
  // level is void here; the slope still picks the TTL edge
  wire ext_up   = i_ext_trig && !ext_prev_r;
  wire ext_dn   = !i_ext_trig && ext_prev_r;
  wire ext_hit  = (ext_up && i_cfg.slope != WTU_SLOPE_FALL) ||
                  (ext_dn && i_cfg.slope != WTU_SLOPE_RISE);
  wire trig_any = integ_on ? 1'b0 : (src_ext ? ext_edge_r : (src_ch && ch_fire));

  // ---------------------------------------------------------------
  // time per division clamp
  // ---------------------------------------------------------------
  wire  [TDIV_N-1:0] tdiv_ok;
  genvar g;
  generate
    for (g = 0; g < TDIV_N; g++) begin : g_tdiv
      assign tdiv_ok[g] = tdiv_us(TDIV_W'(g)) * SCREEN_DIVS <= i_interval_us;
    end
  endgenerate

  logic [TDIV_W-1:0] tdiv_best;
  always_comb begin
    tdiv_best = '0;
    for (int k = 0; k < TDIV_N; k++) begin
      if (tdiv_ok[k] && TDIV_W'(k) <= i_cfg.tdiv_sel) begin
        tdiv_best = TDIV_W'(k);
      end
    end
  end

  wire [31:0] screen_nxt = tdiv_us(tdiv_best) * SCREEN_DIVS * CYC_PER_US;

  // ---------------------------------------------------------------
  // sweep control
  // ---------------------------------------------------------------
  wire tmo_hit   = tmo_r >= TIMEOUT_CYC - 1;
  wire auto_go   = i_cfg.mode == WTU_MODE_AUTO && tmo_hit && !trig_any;
  wire start_now = (state_r == WTU_WAIT) && (trig_any || integ_on || auto_go);
  wire capt_end  = (state_r == WTU_CAPT) && (cnt_r >= screen_r - 32'h1);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      WTU_IDLE: if (i_wave_on && i_update_tick) begin
        state_nxt = WTU_WAIT;
      end
      WTU_WAIT: if (!i_wave_on) begin
        state_nxt = WTU_IDLE;
      end else if (start_now) begin
        state_nxt = WTU_CAPT;
      end
      WTU_CAPT: if (capt_end) begin
        state_nxt = WTU_IDLE;
      end
      default: state_nxt = WTU_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      state_r    <= WTU_IDLE;
      tmo_r      <= '0;
      cnt_r      <= '0;
      screen_r   <= 32'h1;
      tdiv_r     <= '0;
      ext_prev_r <= 1'b0;
      ext_edge_r <= 1'b0;
      frame_r    <= 1'b0;
      refresh_r  <= 1'b0;
      auto_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      ext_prev_r <= i_ext_trig;
      ext_edge_r <= ext_hit;
      tmo_r      <= (state_r == WTU_WAIT) ? tmo_r + 32'h1 : 32'h0;
      // screen left edge is the trigger instant, time zero
      cnt_r      <= start_now ? 32'h0 : cnt_r + 32'h1;
      frame_r    <= start_now;
      refresh_r  <= capt_end;
      if (start_now) begin
        screen_r <= screen_nxt;
        tdiv_r   <= tdiv_best;
        auto_r   <= !trig_any;
      end
    end
  end

  assign o_trig         = trig_any;
  assign o_frame_start  = frame_r;
  assign o_capturing    = state_r == WTU_CAPT;
  assign o_refresh      = refresh_r;
  assign o_auto_refresh = refresh_r && auto_r;
  assign o_screen_cyc   = screen_r;
  assign o_tdiv_eff     = tdiv_r;
  assign o_trig_wait    = state_r == WTU_WAIT;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_waiting_auto;
    state_r == WTU_WAIT && i_wave_on && i_cfg.mode == WTU_MODE_AUTO && tmo_hit;
  endsequence

  sequence s_capture_starts;
    state_r == WTU_CAPT && cnt_r == 32'h0;
  endsequence

  property p_auto_timeout;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      s_waiting_auto |=> s_capture_starts;
  endproperty
  a_auto_timeout: assert property (p_auto_timeout) else $error("auto timeout did not refresh");

  property p_normal_hold;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (state_r == WTU_WAIT && i_cfg.mode == WTU_MODE_NORMAL && !trig_any && !integ_on) |=> state_r != WTU_CAPT;
  endproperty
  a_normal_hold: assert property (p_normal_hold) else $error("normal mode captured without trigger");

  property p_trig_starts;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (state_r == WTU_WAIT && i_wave_on && trig_any) |=> s_capture_starts ##0 o_frame_start;
  endproperty
  a_trig_starts: assert property (p_trig_starts) else $error("trigger did not start measurement");

  property p_ext_delay;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (ext_up && src_ext && i_cfg.slope == WTU_SLOPE_RISE && !integ_on) |=> o_trig;
  endproperty
  a_ext_delay: assert property (p_ext_delay) else $error("external edge not registered in time");

  property p_integ_no_trig;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      integ_on |-> !o_trig;
  endproperty
  a_integ_no_trig: assert property (p_integ_no_trig) else $error("trigger active during integration");

  property p_integ_auto;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (state_r == WTU_WAIT && i_wave_on && integ_on) |=> s_capture_starts;
  endproperty
  a_integ_auto: assert property (p_integ_auto) else $error("integration did not refresh each interval");

  property p_screen_end;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      (state_r == WTU_CAPT && cnt_r == screen_r - 32'h1) |=> o_refresh && state_r == WTU_IDLE;
  endproperty
  a_screen_end: assert property (p_screen_end) else $error("frame did not end at screen duration");

  property p_tdiv_fit;
    @(posedge i_clk_sys) disable iff (i_sys_rst)
      o_frame_start |-> (tdiv_us(o_tdiv_eff) * SCREEN_DIVS <= i_interval_us || o_tdiv_eff == '0);
  endproperty
  a_tdiv_fit: assert property (p_tdiv_fit) else $error("screen longer than update interval");

endmodule : wtu_top

`default_nettype wire

// *** dv/wtu_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// measurement channels and external trigger
// ----------------------------------------
module wtu_src_model (
  input  wire logic          i_clk_sys,
  output var  wtu_pkg::wtu_chans_t o_chans,
  output var  logic          o_smp_valid,
  output var  logic          o_ext_trig
);
  import wtu_pkg::*;

  initial begin
    o_chans     = '0;
    o_smp_valid = 1'b0;
    o_ext_trig  = 1'b0;
  end

  // other channels carry noise so a wrong source pick shows up
  task automatic put(input int ch, input int val, input int gap);
    @(posedge i_clk_sys);
    for (int k = 0; k < NUM_CH; k++) begin
      o_chans[k] <= (k == ch) ? wtu_smp_t'(val) : wtu_smp_t'($urandom);
    end
    o_smp_valid <= 1'b1;
    @(posedge i_clk_sys);
    o_smp_valid <= 1'b0;
    o_chans     <= ~o_chans;
    repeat (gap) @(posedge i_clk_sys);
  endtask : put

  task automatic ext_set(input logic v);
    @(posedge i_clk_sys);
    o_ext_trig <= v;
  endtask : ext_set
endmodule : wtu_src_model

`default_nettype wire

// *** dv/waveform_trigger_unit_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module waveform_trigger_unit_test;
  import wtu_pkg::*;

  localparam int unsigned TO_CYC = 50;

  logic              clk_sys     = 1'b0;
  logic              sys_rst     = 1'b1;
  wtu_cfg_t          cfg         = '0;
  wtu_chans_t        chans;
  logic              smp_valid;
  logic              ext_trig;
  logic              tick        = 1'b0;
  logic              wave_on     = 1'b1;
  logic              integ_run   = 1'b0;
  logic              integ_susp  = 1'b0;
  logic [31:0]       interval_us = 32'h3e8;
  logic              trig;
  logic              refresh;
  logic              auto_refresh;
  logic [31:0]       screen_cyc;
  logic [TDIV_W-1:0] tdiv_eff;
  logic              frame_start;
  logic              capturing;
  logic              trig_wait;
  logic [31:0]       scr_exp     = 32'h64;
  int                cap_n       = 0;
  logic [7:0]        exp_q[$];
  int                failures    = 0;
  int                checks      = 0;

  always #50 clk_sys = ~clk_sys;

  wtu_src_model mdl (.i_clk_sys(clk_sys), .o_chans(chans), .o_smp_valid(smp_valid), .o_ext_trig(ext_trig));

  wtu_top #(.TIMEOUT_CYC(TO_CYC)) uut (
    .i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_cfg(cfg), .i_chans(chans),
    .i_smp_valid(smp_valid), .i_ext_trig(ext_trig), .i_update_tick(tick),
    .i_interval_us(interval_us), .i_wave_on(wave_on), .i_integ_run(integ_run),
    .i_integ_susp(integ_susp), .o_trig(trig), .o_frame_start(frame_start), .o_capturing(capturing),
    .o_refresh(refresh), .o_auto_refresh(auto_refresh), .o_screen_cyc(screen_cyc),
    .o_tdiv_eff(tdiv_eff), .o_trig_wait(trig_wait)
  );

  // ----------------------------------------
  // checking
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check

  // 01 trigger, 02 refresh after a trigger, 03 refresh without one; ff means unexpected
  task automatic take(input logic [7:0] got);
    logic [7:0] want;
    want = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hff;
    check(32'(got), 32'(want));
  endtask : take

  always @(negedge clk_sys) begin
    if (trig === 1'b1) begin
      take(8'h01);
    end
    if (frame_start === 1'b1) begin
      cap_n = 0;
      check({30'h0, capturing, trig_wait}, 32'h2);
    end
    if (capturing === 1'b1) begin
      cap_n++;
    end
    if (refresh === 1'b1) begin
      take({7'h01, auto_refresh});
      check(32'(cap_n), scr_exp);
    end
  end

  task automatic close_out();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  task automatic do_reset();
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
  endtask : do_reset

  task automatic set_cfg(input wtu_mode_t m, input wtu_slope_t s, input logic [3:0] src, input int lvl,
                         input logic cf, input logic [TDIV_W-1:0] td);
    wtu_cfg_t c;
    c.mode     = m;
    c.slope    = s;
    c.src      = src;
    c.level    = LVL_W'(lvl);
    c.cf_hi    = cf;
    c.tdiv_sel = td;
    @(posedge clk_sys);
    cfg <= c;
  endtask : set_cfg

  // waits lo cycles with notes still open, then up to hi for all of them to be met
  task automatic sweep(input logic tk, input int lo, input int hi);
    int n;
    n = exp_q.size();
    @(posedge clk_sys);
    tick <= tk;
    @(posedge clk_sys);
    tick <= 1'b0;
    repeat (lo) @(posedge clk_sys);
    check(32'(exp_q.size() > 0), 32'(n > 0));
    for (int k = lo; k < hi && exp_q.size() > 0; k++) begin
      @(posedge clk_sys);
    end
    check(32'(exp_q.size()), 32'h0);
  endtask : sweep

  // the first sample sits inside the band, so the crossing after it must not fire
  task automatic chan_case(input wtu_slope_t sl, input int ch);
    int lvl;
    int cf;
    int lc;
    int hy;
    lvl = int'($urandom_range(600)) - 300;
    cf  = int'($urandom_range(1));
    lc  = lvl * (cf != 0 ? CF_HI : CF_LO);
    hy  = (cf != 0) ? HYST_CODE_HI : HYST_CODE_LO;
    do_reset();
    set_cfg(WTU_MODE_NORMAL, sl, 4'(ch), lvl, cf[0], '0);
    // display is off here, so random ticks must not start a sweep
    tick        <= 1'($urandom);
    interval_us <= $urandom;
    mdl.put(ch, lc - hy + 5, 1 + int'($urandom_range(2)));
    mdl.put(ch, lc + hy + 5, 1 + int'($urandom_range(2)));
    if (sl != WTU_SLOPE_RISE) exp_q.push_back(8'h01);
    mdl.put(ch, lc - hy - 5, 1 + int'($urandom_range(2)));
    if (sl != WTU_SLOPE_FALL) exp_q.push_back(8'h01);
    mdl.put(ch, lc + hy + 5, 1);
    repeat (3) @(posedge clk_sys);
    check(32'(exp_q.size()), 32'h0);
  endtask : chan_case

  task automatic ext_case(input wtu_slope_t sl);
    do_reset();
    set_cfg(WTU_MODE_NORMAL, sl, SRC_EXT, int'($urandom_range(2000)) - 1000, 1'b0, '0);
    tick <= 1'($urandom);
    if (sl != WTU_SLOPE_FALL) exp_q.push_back(8'h01);
    mdl.ext_set(1'b1);
    repeat (11) @(posedge clk_sys);
    check(32'(exp_q.size()), 32'h0);
    if (sl != WTU_SLOPE_RISE) exp_q.push_back(8'h01);
    mdl.ext_set(1'b0);
    repeat (11) @(posedge clk_sys);
    check(32'(exp_q.size()), 32'h0);
  endtask : ext_case

  initial begin
    void'($urandom(32'h320b));
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    wave_on <= 1'b0;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      chan_case(wtu_slope_t'(ch % 3), ch);
    end
    for (int s = 0; s < 3; s++) begin
      ext_case(wtu_slope_t'(s));
    end
    wave_on     <= 1'b1;
    tick        <= 1'b0;
    interval_us <= 32'h3e8;
    do_reset();
    set_cfg(WTU_MODE_AUTO, WTU_SLOPE_RISE, 4'h9, 0, 1'b0, '0);
    exp_q.push_back(8'h03);
    sweep(1'b1, TO_CYC + 95, TO_CYC + 110);
    set_cfg(WTU_MODE_AUTO, WTU_SLOPE_RISE, SRC_EXT, 0, 1'b0, '0);
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h02);
    fork
      sweep(1'b1, 20, 140);
      mdl.ext_set(1'b1);
    join
    // a pin held high across reset looks like a fresh edge afterwards
    mdl.ext_set(1'b0);
    do_reset();
    set_cfg(WTU_MODE_NORMAL, WTU_SLOPE_RISE, 4'h9, 0, 1'b0, 5'h10);
    interval_us <= 32'h64;
    sweep(1'b1, 300, 300);
    @(negedge clk_sys);
    check(32'(trig_wait), 32'h1);
    set_cfg(WTU_MODE_NORMAL, WTU_SLOPE_RISE, SRC_EXT, 0, 1'b0, 5'h10);
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h02);
    scr_exp = 32'h3e8;
    mdl.ext_set(1'b1);
    sweep(1'b0, 950, 1050);
    @(negedge clk_sys);
    check(screen_cyc, 32'h3e8);
    check(32'(tdiv_eff), 32'h3);
    scr_exp = 32'h64;
    mdl.ext_set(1'b0);
    wave_on <= 1'b0;
    sweep(1'b1, 30, 30);
    wave_on <= 1'b1;
    interval_us <= 32'h3e8;
    for (int k = 0; k < 2; k++) begin
      do_reset();
      set_cfg(WTU_MODE_NORMAL, WTU_SLOPE_BOTH, SRC_EXT, 0, 1'b0, '0);
      integ_run  <= (k == 0);
      integ_susp <= (k == 1);
      exp_q.push_back(8'h03);
      fork
        sweep(1'b1, 90, 110);
        mdl.ext_set(~ext_trig);
      join
      integ_run  <= 1'b0;
      integ_susp <= 1'b0;
    end
    repeat (5) @(posedge clk_sys);
    close_out();
  end

  // the whole run needs about 2100 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    close_out();
  end
endmodule : waveform_trigger_unit_test

`default_nettype wire
